// ===== design/atr_recorder.sv
`timescale 1ns/100ps
`default_nettype none
module atr_recorder #(
    parameter int DEPTH = atr_pkg::REC_DEPTH,
    parameter int BASE_CYCLES = atr_pkg::BASE_CYCLES,
    parameter int SEC_CYCLES = atr_pkg::SEC_CYCLES,
    parameter int AUX_W = 32
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // Monitored channels
    input wire logic [atr_pkg::N_ANA*atr_pkg::ANA_W-1:0] ANALOG_I,
    input wire logic [atr_pkg::N_DIG-1:0] DIGITAL_I,
    input wire logic [AUX_W-1:0] AUX_I,
    // Alarm and suspend sources
    input wire logic ALARM_I,
    input wire logic [15:0] ALARM_CODE_I,
    input wire logic GRAPH_ACTIVE_I,
    input wire logic ANALYZER_ACTIVE_I,
    input wire logic SOFT_RESET_I,
    // Settings
    input wire logic [15:0] RECORDER_SWITCH_TIME_SETTING_I,
    input wire logic [15:0] DESIRED_ALARM_TRIGGER_SELECT_I,
    input wire logic RECORDER_OPERATION_MODE_SELECT_I,
    input wire logic [1:0] SAMPLING_START_SELECT_I,
    input wire logic [3:0] CYCLE_SEL_I,
    input wire logic [1:0] TRIG_SRC_I,
    input wire logic [6:0] TRIG_POS_I,
    input wire logic [2:0] TRIG_ANA_CH_I,
    input wire logic [31:0] TRIG_LEVEL_I,
    input wire logic [2:0] TRIG_DIG_CH_I,
    input wire logic TRIG_DIG_RISE_I,
    input wire logic [3:0] HIST_SEL_I,
    // Record stream out
    output logic REC_VALID_O,
    output logic [atr_pkg::REC_W:0] REC_DATA_O,
    input wire logic REC_READY_I,
    // Status
    output logic ACTIVE_O,
    output logic SAVING_O,
    output logic SUSPENDED_O,
    output logic [4:0] HIST_COUNT_O,
    output logic [29:0] HIST_ENTRY_O,
    output logic [AUX_W-1:0] AUX_O,
    output logic AUX_ALARM_O
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int RW = atr_pkg::REC_W;
    localparam int SW = $clog2(SEC_CYCLES);
    if (DEPTH < 2 || (1 << AW) != DEPTH || DEPTH > atr_pkg::REC_DEPTH)
    begin : g_chk
        $error("atr_recorder: DEPTH must be a power of two up to 1024");
    end

    function automatic logic [31:0] ana_slice(
        input logic [atr_pkg::N_ANA*atr_pkg::ANA_W-1:0] v,
        input logic [2:0] ch);
        logic [2:0] c;
        c = (ch > 3'h6) ? 3'h6 : ch;
        return v[c*atr_pkg::ANA_W +: atr_pkg::ANA_W];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Settings decode and suspend control

    logic manual, disabled, run, tick, start_on;
    logic [3:0] step;
    logic [6:0] pos;
    logic [CW-1:0] pre_tgt, post_tgt;
    logic hold_q, hold_d;
    logic [SW-1:0] cyc_q, cyc_d;
    logic [15:0] sec_q, sec_d;
    atr_pkg::state_type state_q, state_d;
    logic done_q, done_d;

    assign manual = (RECORDER_OPERATION_MODE_SELECT_I
                     == atr_pkg::MODE_MANUAL);
    assign disabled = (RECORDER_SWITCH_TIME_SETTING_I
                       == atr_pkg::SWITCH_DISABLED);
    assign start_on = (SAMPLING_START_SELECT_I == atr_pkg::START_SINGLE)
        || (SAMPLING_START_SELECT_I == atr_pkg::START_CONT);
    assign run = !disabled && !GRAPH_ACTIVE_I && !ANALYZER_ACTIVE_I
        && !hold_q && (!manual || (start_on && !done_q));

    always_comb begin
        if (manual) begin
            step = (CYCLE_SEL_I > atr_pkg::MAX_STEP) ? atr_pkg::MAX_STEP
                                                     : CYCLE_SEL_I;
            pos = (TRIG_POS_I > atr_pkg::MAX_POS) ? atr_pkg::MAX_POS
                                                  : TRIG_POS_I;
        end else begin
            pos = atr_pkg::AUTO_POS;
            if (state_q == atr_pkg::ST_POST) begin
                step = atr_pkg::AUTO_NEAR;
            end else if (DESIRED_ALARM_TRIGGER_SELECT_I
                         == atr_pkg::ANY_ALARM) begin
                step = atr_pkg::AUTO_FAR_ANY;
            end else begin
                step = atr_pkg::AUTO_FAR_SEL;
            end
        end
        pre_tgt = CW'(DEPTH * int'(pos) / atr_pkg::PCT_FULL);
        post_tgt = CW'(DEPTH) - pre_tgt;
    end

    // Hold after graph use until switch time, or soft reset
    always_comb begin
        hold_d = hold_q;
        cyc_d = cyc_q;
        sec_d = sec_q;
        if (GRAPH_ACTIVE_I) begin
            hold_d = 1'b1;
            cyc_d = '0;
            sec_d = '0;
        end else if (hold_q) begin
            if (SOFT_RESET_I || sec_q >= RECORDER_SWITCH_TIME_SETTING_I)
            begin
                hold_d = 1'b0;
            end else if (cyc_q == SW'(SEC_CYCLES - 1)) begin
                cyc_d = '0;
                sec_d = sec_q + 16'h0001;
            end else begin
                cyc_d = cyc_q + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            hold_q <= 1'b0;
            cyc_q <= '0;
            sec_q <= '0;
        end else begin
            hold_q <= hold_d;
            cyc_q <= cyc_d;
            sec_q <= sec_d;
        end
    end

    atr_tick #(.BASE(BASE_CYCLES)) u_tick (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .run_i(state_q == atr_pkg::ST_PRE || state_q == atr_pkg::ST_POST),
        .step_i(step),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Trigger detection

    logic [31:0] cur_a, prev_a_q, prev_a_d;
    logic prev_g_q, prev_g_d, cur_g, alarm_hit, trig;

    assign cur_a = ana_slice(ANALOG_I, TRIG_ANA_CH_I);
    assign cur_g = DIGITAL_I[TRIG_DIG_CH_I];
    // Auto mode may be narrowed to one alarm code
    assign alarm_hit = ALARM_I && (manual
        || DESIRED_ALARM_TRIGGER_SELECT_I == atr_pkg::ANY_ALARM
        || DESIRED_ALARM_TRIGGER_SELECT_I == ALARM_CODE_I);

    // Analog and digital only see sample instants, so long
    // intervals can miss short events
    always_comb begin
        trig = 1'b0;
        if (state_q == atr_pkg::ST_PRE && run) begin
            if (!manual || TRIG_SRC_I == atr_pkg::TRIG_ALARM) begin
                trig = alarm_hit;
            end else if (TRIG_SRC_I == atr_pkg::TRIG_ANALOG) begin
                trig = tick && ($signed(prev_a_q) < $signed(TRIG_LEVEL_I))
                    && ($signed(cur_a) >= $signed(TRIG_LEVEL_I));
            end else if (TRIG_SRC_I == atr_pkg::TRIG_DIGITAL) begin
                trig = tick && (prev_g_q != cur_g)
                    && (cur_g == TRIG_DIG_RISE_I);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capture sequencer

    logic [RW-1:0] ring [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] fill_q, fill_d, post_q, post_d, left_q, left_d;
    logic [CW-1:0] len_q, len_d, avail;
    logic [1:0] src_q, src_d;
    logic [15:0] code_q, code_d;
    logic [AUX_W-1:0] aux_q, aux_d;
    logic auxa_q, auxa_d, ring_we, push, last, finish;
    atr_stream_if #(.W(RW + 1)) fin ();
    atr_stream_if #(.W(RW + 1)) fout ();

    always_comb begin
        state_d = state_q;
        wr_d = wr_q;
        rd_d = rd_q;
        fill_d = fill_q;
        post_d = post_q;
        left_d = left_q;
        len_d = len_q;
        src_d = src_q;
        code_d = code_q;
        aux_d = aux_q;
        auxa_d = auxa_q;
        done_d = done_q;
        prev_a_d = tick ? cur_a : prev_a_q;
        prev_g_d = tick ? cur_g : prev_g_q;
        avail = (fill_q < pre_tgt) ? fill_q : pre_tgt;
        ring_we = 1'b0;
        push = 1'b0;
        last = 1'b0;
        finish = 1'b0;
        if (SAMPLING_START_SELECT_I == atr_pkg::START_STOP) begin
            done_d = 1'b0;
        end
        unique case (state_q)
            atr_pkg::ST_IDLE: begin
                fill_d = '0;
                if (run) begin
                    state_d = atr_pkg::ST_PRE;
                end
            end
            atr_pkg::ST_PRE: begin
                if (!run) begin
                    state_d = atr_pkg::ST_IDLE;
                end else begin
                    if (tick) begin
                        ring_we = 1'b1;
                        wr_d = wr_q + 1'b1;
                        if (fill_q != CW'(DEPTH)) begin
                            fill_d = fill_q + 1'b1;
                        end
                    end
                    if (trig) begin
                        rd_d = wr_q - avail[AW-1:0];
                        len_d = avail + post_tgt;
                        left_d = avail + post_tgt;
                        src_d = manual ? TRIG_SRC_I : atr_pkg::TRIG_ALARM;
                        code_d = (!manual || TRIG_SRC_I
                                  == atr_pkg::TRIG_ALARM) ? ALARM_CODE_I
                                                          : 16'h0000;
                        aux_d = AUX_I;
                        auxa_d = (src_d == atr_pkg::TRIG_ALARM);
                        if (post_tgt == '0) begin
                            ring_we = 1'b0;
                            wr_d = wr_q;
                            state_d = atr_pkg::ST_SAVE;
                        end else if (tick && post_tgt == CW'(1)) begin
                            state_d = atr_pkg::ST_SAVE;
                        end else begin
                            post_d = tick ? post_tgt - 1'b1 : post_tgt;
                            state_d = atr_pkg::ST_POST;
                        end
                    end
                end
            end
            atr_pkg::ST_POST: begin
                if (!run) begin
                    state_d = atr_pkg::ST_IDLE;
                end else if (tick) begin
                    ring_we = 1'b1;
                    wr_d = wr_q + 1'b1;
                    post_d = post_q - 1'b1;
                    if (post_q == CW'(1)) begin
                        state_d = atr_pkg::ST_SAVE;
                    end
                end
            end
            atr_pkg::ST_SAVE: begin
                // Save finishes even if suspended meanwhile
                if (left_q == '0) begin
                    finish = 1'b1;
                end else if (fin.ready) begin
                    push = 1'b1;
                    rd_d = rd_q + 1'b1;
                    left_d = left_q - 1'b1;
                    last = (left_q == CW'(1));
                    finish = last;
                end
                if (finish) begin
                    state_d = atr_pkg::ST_IDLE;
                    fill_d = '0;
                    if (manual && SAMPLING_START_SELECT_I
                        == atr_pkg::START_SINGLE) begin
                        done_d = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (ring_we) begin
            ring[wr_q] <= {DIGITAL_I, ANALOG_I};
        end
        if (RESET_I) begin
            state_q <= atr_pkg::ST_IDLE;
            wr_q <= '0;
            rd_q <= '0;
            fill_q <= '0;
            post_q <= '0;
            left_q <= '0;
            len_q <= '0;
            src_q <= atr_pkg::TRIG_ALARM;
            code_q <= '0;
            aux_q <= '0;
            auxa_q <= 1'b0;
            done_q <= 1'b0;
            prev_a_q <= '0;
            prev_g_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            fill_q <= fill_d;
            post_q <= post_d;
            left_q <= left_d;
            len_q <= len_d;
            src_q <= src_d;
            code_q <= code_d;
            aux_q <= aux_d;
            auxa_q <= auxa_d;
            done_q <= done_d;
            prev_a_q <= prev_a_d;
            prev_g_q <= prev_g_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output buffer; a stalled reader stalls the save

    assign fin.valid = push;
    assign fin.data = {last, ring[rd_q]};
    assign fout.ready = REC_READY_I;
    assign REC_VALID_O = fout.valid;
    assign REC_DATA_O = fout.data;

    atr_fifo #(.W(RW + 1), .DEPTH(atr_pkg::FIFO_DEPTH)) u_fifo (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .in_s(fin),
        .out_s(fout)
    );

    ////////////////////////////////////////////////////////////////////
    // History table and status

    atr_pkg::hist_type hist [atr_pkg::N_HIST];
    atr_pkg::hist_type hent;
    logic [3:0] hwr_q, hwr_d, hidx;
    logic [4:0] hcnt_q, hcnt_d;
    logic [29:0] hout_d;
    logic act_d, save_d, susp_d;

    always_comb begin
        hent = '{valid: 1'b1, src: src_q,
                 code: auxa_q ? code_q : 16'h0000, len: 11'(len_q)};
        hwr_d = finish ? hwr_q + 4'h1 : hwr_q;
        hcnt_d = hcnt_q;
        if (finish && hcnt_q != 5'(atr_pkg::N_HIST)) begin
            hcnt_d = hcnt_q + 5'h01;
        end
        hidx = hwr_q - 4'h1 - HIST_SEL_I;
        hout_d = ({1'b0, HIST_SEL_I} < hcnt_q) ? hist[hidx] : '0;
        act_d = (state_d == atr_pkg::ST_PRE || state_d == atr_pkg::ST_POST);
        save_d = (state_d == atr_pkg::ST_SAVE);
        susp_d = hold_d || GRAPH_ACTIVE_I || ANALYZER_ACTIVE_I || disabled;
    end

    always_ff @(posedge CLK_I) begin
        if (finish) begin
            hist[hwr_q] <= hent;
        end
        if (RESET_I) begin
            hwr_q <= '0;
            hcnt_q <= '0;
            HIST_ENTRY_O <= '0;
            HIST_COUNT_O <= '0;
            ACTIVE_O <= 1'b0;
            SAVING_O <= 1'b0;
            SUSPENDED_O <= 1'b0;
            AUX_O <= '0;
            AUX_ALARM_O <= 1'b0;
        end else begin
            hwr_q <= hwr_d;
            hcnt_q <= hcnt_d;
            HIST_ENTRY_O <= hout_d;
            HIST_COUNT_O <= hcnt_d;
            ACTIVE_O <= act_d;
            SAVING_O <= save_d;
            SUSPENDED_O <= susp_d;
            AUX_O <= aux_d;
            AUX_ALARM_O <= auxa_d;
        end
    end
endmodule // atr_recorder
`default_nettype wire

// ===== design/atr_pkg.sv
package atr_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int BASE_TIME_US = 250;
    localparam int BASE_CYCLES = BASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int SECOND_TIME_MS = 1000;
    localparam int SEC_CYCLES = SECOND_TIME_MS * 1000000 / CLK_PERIOD_NS;

    localparam int N_ANA = 7;
    localparam int ANA_W = 32;
    localparam int N_DIG = 8;
    localparam int REC_W = N_ANA * ANA_W + N_DIG;
    localparam int REC_DEPTH = 1024;
    localparam int N_HIST = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int PCT_FULL = 100;

    localparam logic [3:0] MAX_STEP = 4'hC;
    localparam logic [3:0] AUTO_FAR_ANY = 4'h3;
    localparam logic [3:0] AUTO_FAR_SEL = 4'h1;
    localparam logic [3:0] AUTO_NEAR = 4'h0;
    localparam logic [6:0] AUTO_POS = 7'h5A;
    localparam logic [6:0] MAX_POS = 7'h64;

    localparam logic MODE_AUTO = 1'h0;
    localparam logic MODE_MANUAL = 1'h1;
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_SINGLE = 2'h1;
    localparam logic [1:0] START_CONT = 2'h2;
    localparam logic [1:0] TRIG_ALARM = 2'h0;
    localparam logic [1:0] TRIG_ANALOG = 2'h1;
    localparam logic [1:0] TRIG_DIGITAL = 2'h2;
    localparam logic [15:0] SWITCH_DISABLED = 16'hFFFF;
    localparam logic [15:0] ANY_ALARM = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PRE,
        ST_POST,
        ST_SAVE
    } state_type;

    typedef struct packed {
        logic valid;
        logic [1:0] src;
        logic [15:0] code;
        logic [10:0] len;
    } hist_type;

endpackage

// ===== design/atr_stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface atr_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== design/atr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module atr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    atr_stream_if.snk in_s,
    atr_stream_if.src out_s
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("atr_fifo: DEPTH must be a power of two");
    end

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_s.ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data = mem[rd_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= in_s.data;
        end
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // atr_fifo
`default_nettype wire

// ===== design/atr_tick.sv
`timescale 1ns/100ps
`default_nettype none
module atr_tick #(
    parameter int BASE = 25000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [3:0] step_i,
    output logic tick_o
);
    localparam int BW = $clog2(BASE);
    if (BASE < 2) begin : g_chk
        $error("atr_tick: BASE must be at least 2");
    end

    logic [BW-1:0] base_q, base_d;
    logic [12:0] div_q, div_d;
    logic tick_q, tick_d;
    logic [12:0] lim;

    // Interval is the base period times two to the step
    always_comb begin
        lim = (13'h0001 << step_i) - 13'h0001;
        base_d = base_q + 1'b1;
        div_d = div_q;
        tick_d = 1'b0;
        if (!run_i) begin
            base_d = '0;
            div_d = '0;
        end else if (base_q == BW'(BASE - 1)) begin
            base_d = '0;
            div_d = div_q + 13'h0001;
            // Compare with >= so a shorter step takes effect at once
            if (div_q >= lim) begin
                div_d = '0;
                tick_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_q <= '0;
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            base_q <= base_d;
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule // atr_tick
`default_nettype wire

// ===== tb/atr_recorder_sva.sv
`timescale 1ns/100ps
`default_nettype none
module atr_recorder_chk (
    // Clock, reset and settings
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic GRAPH_ACTIVE_I,
    input wire logic [15:0] RECORDER_SWITCH_TIME_SETTING_I,
    input wire logic RECORDER_OPERATION_MODE_SELECT_I,
    input wire logic [1:0] SAMPLING_START_SELECT_I,
    input wire logic [3:0] HIST_SEL_I,
    input wire logic REC_READY_I,
    // Observed outputs
    input wire logic REC_VALID_O,
    input wire logic [atr_pkg::REC_W:0] REC_DATA_O,
    input wire logic ACTIVE_O,
    input wire logic SAVING_O,
    input wire logic SUSPENDED_O,
    input wire logic [4:0] HIST_COUNT_O,
    input wire logic [29:0] HIST_ENTRY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    rst_clear_a: assert property ($fell(RESET_I) |-> !ACTIVE_O && !SAVING_O
        && HIST_COUNT_O == 5'h0) else $error("status not clear after reset");
    hist_bound_a: assert property (HIST_COUNT_O <= 5'h10)
        else $error("history count above sixteen");
    act_save_a: assert property (!(ACTIVE_O && SAVING_O))
        else $error("sampling while saving");
    count_step_a: assert property (!$past(RESET_I) && $changed(HIST_COUNT_O)
        |-> HIST_COUNT_O == $past(HIST_COUNT_O) + 5'h1)
        else $error("history count jumped");
    save_src_a: assert property ($rose(SAVING_O) |-> $past(ACTIVE_O))
        else $error("save without sampling");
    graph_susp_a: assert property (GRAPH_ACTIVE_I [*4]
        |-> SUSPENDED_O && !ACTIVE_O) else $error("active during graph");
    off_idle_a: assert property ((RECORDER_SWITCH_TIME_SETTING_I
        == atr_pkg::SWITCH_DISABLED) [*4] |-> SUSPENDED_O && !ACTIVE_O)
        else $error("active while disabled");
    stop_idle_a: assert property ((RECORDER_OPERATION_MODE_SELECT_I
        && SAMPLING_START_SELECT_I == 2'h0) [*4] |-> !ACTIVE_O)
        else $error("active while stopped");
    stream_hold_a: assert property (REC_VALID_O && !REC_READY_I
        |=> REC_VALID_O && $stable(REC_DATA_O)) else $error("word dropped");
    hist_none_a: assert property ({1'b0, HIST_SEL_I} >= HIST_COUNT_O
        |=> HIST_ENTRY_O == 30'h0) else $error("entry beyond count");
    hist_valid_a: assert property ({1'b0, HIST_SEL_I} < HIST_COUNT_O
        |=> HIST_ENTRY_O[29]) else $error("stored entry not valid");
endmodule // atr_recorder_chk
bind atr_recorder atr_recorder_chk u_atr_recorder_chk (.*);
`default_nettype wire

// ===== tb/atr_monitor_model.sv
`timescale 1ns/100ps
`default_nettype none
module atr_monitor_model (
    // Clock and trigger request, 3 = none
    input wire logic clk_i,
    input wire logic [1:0] fire_i,
    // Monitor signals
    output logic [223:0] analog_o,
    output logic [7:0] digital_o,
    output logic alarm_o,
    output logic [15:0] alarm_code_o
);
    logic [31:0] cnt_q = 32'h0;
    logic [5:0] ana_q = 6'h0;
    logic [5:0] dig_q = 6'h0;
    // Levels hold many ticks so a slow sampler still sees them
    always @(negedge clk_i) begin
        cnt_q <= cnt_q + 32'h1;
        ana_q <= (fire_i == 2'h1) ? 6'h28 : ana_q - 6'(ana_q != 6'h0);
        dig_q <= (fire_i == 2'h2) ? 6'h28 : dig_q - 6'(dig_q != 6'h0);
    end
    assign alarm_o = fire_i == 2'h0;
    // Code is junk outside an alarm, as a real source would leave it
    assign alarm_code_o = alarm_o ? 16'h0042 : cnt_q[15:0];
    assign analog_o = {{4{cnt_q}}, (ana_q != 6'h0) ? 32'h200 : 32'h0,
        {2{cnt_q}}};
    assign digital_o = {cnt_q[7:4], dig_q != 6'h0, cnt_q[2:0]};
endmodule // atr_monitor_model
`default_nettype wire

// ===== tb/atr_recorder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module atr_recorder_tb;
    localparam int DEPTH = 16;
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic [223:0] ANALOG_I;
    logic [7:0] DIGITAL_I;
    logic [31:0] AUX_I = 32'h0;
    logic ALARM_I;
    logic [15:0] ALARM_CODE_I;
    logic GRAPH_ACTIVE_I = 1'b0;
    logic ANALYZER_ACTIVE_I = 1'b0;
    logic SOFT_RESET_I = 1'b0;
    logic [15:0] RECORDER_SWITCH_TIME_SETTING_I = 16'h0001;
    logic [15:0] DESIRED_ALARM_TRIGGER_SELECT_I = 16'h0077;
    logic RECORDER_OPERATION_MODE_SELECT_I = 1'b0;
    logic [1:0] SAMPLING_START_SELECT_I = 2'h0;
    logic [3:0] CYCLE_SEL_I = 4'h0;
    logic [1:0] TRIG_SRC_I = 2'h3;
    logic [6:0] TRIG_POS_I = 7'h0;
    logic [2:0] TRIG_ANA_CH_I = 3'h2;
    logic [31:0] TRIG_LEVEL_I = 32'h100;
    logic [2:0] TRIG_DIG_CH_I = 3'h3;
    logic TRIG_DIG_RISE_I = 1'b1;
    logic [3:0] HIST_SEL_I = 4'h0;
    logic REC_READY_I = 1'b1;
    logic REC_VALID_O, ACTIVE_O, SAVING_O, SUSPENDED_O, AUX_ALARM_O;
    logic [232:0] REC_DATA_O;
    logic [4:0] HIST_COUNT_O;
    logic [29:0] HIST_ENTRY_O;
    logic [31:0] AUX_O;
    logic [31:0] aux_exp;
    logic [1:0] fire = 2'h3;
    logic [15:0] lfsr = 16'h000B;
    logic last_seen = 1'b0;
    int n_mismatch = 0, cmp_count = 0, n_words = 0;
    atr_recorder #(.DEPTH(DEPTH), .BASE_CYCLES(4), .SEC_CYCLES(10))
        u_atr_recorder (.*);
    atr_monitor_model u_atr_monitor_model (.clk_i(CLK_I), .fire_i(fire),
        .analog_o(ANALOG_I), .digital_o(DIGITAL_I), .alarm_o(ALARM_I),
        .alarm_code_o(ALARM_CODE_I));
    always #5 CLK_I = ~CLK_I;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Cycles to let the pre-trigger part fill, with two ticks of margin
    function automatic int pre_hold(input logic [6:0] pos, input int tick);
        int p;
        p = (pos > 7'd100) ? 100 : int'(pos);
        return (DEPTH * p / 100 + 2) * tick;
    endfunction
    // Reader stalls about one cycle in four
    always @(negedge CLK_I) begin
        lfsr <= nxt(lfsr);
        REC_READY_I <= lfsr[0] | lfsr[1];
        AUX_I <= {lfsr, lfsr};
    end
    always @(posedge CLK_I) begin
        if (REC_VALID_O === 1'b1 && REC_READY_I) begin
            n_words++;
            last_seen = REC_DATA_O[232];
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic [1:0] src);
        fire = src;
        @(posedge CLK_I);
        aux_exp = AUX_I;
        @(negedge CLK_I);
        fire = 2'h3;
    endtask
    // Second trigger lands in post or save phase and must be ignored
    task automatic capture(input logic [1:0] src, input int hold);
        int w0, i;
        logic [4:0] c0;
        w0 = n_words;
        c0 = HIST_COUNT_O;
        repeat (hold) @(negedge CLK_I);
        pulse(src);
        if (src == 2'h0) chk(AUX_O, aux_exp);
        repeat (8) @(negedge CLK_I);
        pulse(src);
        for (i = 0; i < 4000 && (SAVING_O !== 1'b0 || REC_VALID_O !== 1'b0
                || n_words - w0 < DEPTH); i++) begin
            @(negedge CLK_I);
        end
        chk(n_words - w0, DEPTH);
        chk(last_seen, 1'b1);
        chk(HIST_COUNT_O, (c0 == 5'h10) ? 5'h10 : c0 + 5'h1);
        chk(AUX_ALARM_O, src == 2'h0);
        chk(HIST_ENTRY_O, {1'b1, src, (src == 2'h0) ? 16'h0042 : 16'h0,
            11'(DEPTH)});
    endtask
    task automatic none();
        logic [4:0] c0;
        c0 = HIST_COUNT_O;
        repeat (4) @(negedge CLK_I);
        pulse(2'h0);
        repeat (300) @(negedge CLK_I);
        chk(HIST_COUNT_O, c0);
    endtask
    task automatic restart(input logic [1:0] start);
        SAMPLING_START_SELECT_I = 2'h0;
        repeat (4) @(negedge CLK_I);
        SAMPLING_START_SELECT_I = start;
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Whole run is near 3000 cycles; twenty times that means a hang
    initial begin
        repeat (60000) @(posedge CLK_I);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge CLK_I);
        RESET_I = 1'b0;
        none();
        DESIRED_ALARM_TRIGGER_SELECT_I = 16'h0;
        capture(2'h0, pre_hold(7'd90, 32));
        DESIRED_ALARM_TRIGGER_SELECT_I = 16'h0042;
        capture(2'h0, pre_hold(7'd90, 8));
        $display("automatic mode done");
        RECORDER_OPERATION_MODE_SELECT_I = 1'b1;
        TRIG_POS_I = 7'd50;
        for (int s = 0; s < 3; s++) begin
            TRIG_SRC_I = 2'(s);
            restart(2'h2);
            capture(2'(s), pre_hold(7'd50, 4));
        end
        TRIG_SRC_I = 2'h0;
        for (int k = 0; k < 13; k++) begin
            TRIG_POS_I = (k == 0) ? 7'h7F : 7'(lfsr % 16'd101);
            restart(2'h2);
            capture(2'h0, pre_hold(TRIG_POS_I, 4));
        end
        restart(2'h1);
        capture(2'h0, pre_hold(TRIG_POS_I, 4));
        none();
        $display("manual mode done");
        restart(2'h2);
        RECORDER_SWITCH_TIME_SETTING_I = 16'h0005;
        GRAPH_ACTIVE_I = 1'b1;
        repeat (5) @(negedge CLK_I);
        chk(ACTIVE_O, 1'b0);
        GRAPH_ACTIVE_I = 1'b0;
        repeat (20) @(negedge CLK_I);
        chk(SUSPENDED_O, 1'b1);
        SOFT_RESET_I = 1'b1;
        @(negedge CLK_I);
        SOFT_RESET_I = 1'b0;
        repeat (5) @(negedge CLK_I);
        chk(SUSPENDED_O, 1'b0);
        ANALYZER_ACTIVE_I = 1'b1;
        repeat (5) @(negedge CLK_I);
        chk(SUSPENDED_O, 1'b1);
        ANALYZER_ACTIVE_I = 1'b0;
        GRAPH_ACTIVE_I = 1'b1;
        @(negedge CLK_I);
        GRAPH_ACTIVE_I = 1'b0;
        repeat (80) @(negedge CLK_I);
        chk(ACTIVE_O, 1'b1);
        RECORDER_SWITCH_TIME_SETTING_I = 16'hFFFF;
        repeat (5) @(negedge CLK_I);
        chk(ACTIVE_O, 1'b0);
        $display("suspend done");
        stop_test();
    end
endmodule // atr_recorder_tb
`default_nettype wire
